// ===== dae_pkg.sv
// constants for the dma alignment error status block
// assumes a 32-bit apb register bus and 32 dma channels
package dae_pkg;
  localparam int unsigned NUM_CHANNELS  = 32;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned WIDTH_W       = 2;
  localparam int unsigned LOW_ADDR_W    = 2;

  localparam logic [ADDR_W-1:0] OFS_ALIGN_UNMASK = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_ALIGN_FLAGS  = 12'h01c;

  localparam logic [DATA_W-1:0] RST_ALIGN_UNMASK = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_ALIGN_FLAGS  = 32'h0000_0000;

  localparam logic [WIDTH_W-1:0] ITEM_WIDTH_RSVD = 2'h0;
  localparam logic [WIDTH_W-1:0] ITEM_WIDTH_BYTE = 2'h1;
  localparam logic [WIDTH_W-1:0] ITEM_WIDTH_HALF = 2'h2;
  localparam logic [WIDTH_W-1:0] ITEM_WIDTH_WORD = 2'h3;
endpackage

// ===== dae_align_chk.sv
// one channel's address alignment check against its item width
// assumes width and low address bits are stable, same clock domain
`timescale 1ns/1ps
module dae_align_chk
  import dae_pkg::*;
(
  input  wire logic [dae_pkg::WIDTH_W-1:0]    channel_item_width_in,
  input  wire logic [dae_pkg::LOW_ADDR_W-1:0] src_addr_low_in,
  input  wire logic [dae_pkg::LOW_ADDR_W-1:0] dst_addr_low_in,
  output logic                                misaligned_out
);
  always_comb
  begin
    unique case (channel_item_width_in)
      ITEM_WIDTH_WORD: misaligned_out = (src_addr_low_in != 2'h0) || (dst_addr_low_in != 2'h0);
      ITEM_WIDTH_HALF: misaligned_out = src_addr_low_in[0] || dst_addr_low_in[0];
      // byte and the reserved code both move single bytes
      ITEM_WIDTH_BYTE,
      ITEM_WIDTH_RSVD: misaligned_out = 1'b0;
    endcase
  end
endmodule

// ===== dae_align_error_status.sv
// per-channel sticky alignment error flags with unmask, apb slave
// assumes channel address/width inputs and check strobes come from
// logic on sys_clk_in; apb master on the same clock
// a low ce_in freezes every register, apb answer included
`timescale 1ns/1ps

// Contract
// - one flag per channel, bit n is channel n
// - set flag on misaligned source or target
// - flag one means error interrupt raised
// - flag zero means no error raised
// - readable, write-one clears, resets to zero
// - unmask bit gates interrupt, resets zero
// - word needs low two zero, half low one
// - width codes byte 1, half 2, word 3
module dae_align_error_status
  import dae_pkg::*;
(
  input  wire logic                                         sys_clk_in,
  input  wire logic                                         srst_in,
  input  wire logic                                         ce_in,
  input  wire logic                                         psel_in,
  input  wire logic                                         penable_in,
  input  wire logic                                         pwrite_in,
  input  wire logic [dae_pkg::ADDR_W-1:0]                   paddr_in,
  input  wire logic [dae_pkg::DATA_W-1:0]                   pwdata_in,
  input  wire logic [dae_pkg::DATA_W/8-1:0]                 pstrb_in,
  input  wire logic [dae_pkg::NUM_CHANNELS-1:0]             chan_check_in,
  input  wire logic [dae_pkg::NUM_CHANNELS*dae_pkg::WIDTH_W-1:0]    channel_item_width_in,
  input  wire logic [dae_pkg::NUM_CHANNELS*dae_pkg::LOW_ADDR_W-1:0] src_addr_low_in,
  input  wire logic [dae_pkg::NUM_CHANNELS*dae_pkg::LOW_ADDR_W-1:0] dst_addr_low_in,
  output logic      [dae_pkg::DATA_W-1:0]                   prdata_out,
  output logic                                              pready_out,
  output logic                                              pslverr_out,
  output logic      [dae_pkg::NUM_CHANNELS-1:0]             align_error_irq_out
);
  import dae_pkg::*;

  logic [NUM_CHANNELS-1:0] flags_q;
  logic [NUM_CHANNELS-1:0] flags_d;
  logic [NUM_CHANNELS-1:0] unmask_q;
  logic [NUM_CHANNELS-1:0] unmask_d;
  logic [NUM_CHANNELS-1:0] misaligned;
  logic [NUM_CHANNELS-1:0] set_mask;
  logic [NUM_CHANNELS-1:0] clear_mask;
  logic [NUM_CHANNELS-1:0] irq_d;

  // apb decode
  logic [DATA_W-1:0]       byte_mask;
  logic [DATA_W-1:0]       rdata_d;
  logic                    sel_flags;
  logic                    sel_unmask;
  logic                    mapped;
  logic                    access;
  logic                    answer;
  logic                    commit;
  logic                    wr_flags;
  logic                    wr_unmask;
  logic                    rd_answer;

  // one purely combinational checker per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++)
    begin : g_chk
      dae_align_chk u_chk (
        .channel_item_width_in (channel_item_width_in[gi*WIDTH_W +: WIDTH_W]),
        .src_addr_low_in       (src_addr_low_in[gi*LOW_ADDR_W +: LOW_ADDR_W]),
        .dst_addr_low_in       (dst_addr_low_in[gi*LOW_ADDR_W +: LOW_ADDR_W]),
        .misaligned_out        (misaligned[gi])
      );
    end
  endgenerate

  // one wait state: pready rises on the second access cycle
  assign access     = psel_in && penable_in;
  assign answer     = access && !pready_out;
  assign commit     = access && pready_out;
  assign sel_flags  = (paddr_in == OFS_ALIGN_FLAGS);
  assign sel_unmask = (paddr_in == OFS_ALIGN_UNMASK);
  assign mapped     = sel_flags || sel_unmask;
  assign wr_flags   = commit && pwrite_in && sel_flags;
  assign wr_unmask  = commit && pwrite_in && sel_unmask;
  assign rd_answer  = answer && !pwrite_in;

  always_comb
  begin
    for (int b = 0; b < DATA_W/8; b++)
    begin
      byte_mask[b*8 +: 8] = {8{pstrb_in[b]}};
    end
  end

  // only ones written clear; zeros leave flags alone
  assign clear_mask = wr_flags ? (pwdata_in & byte_mask) : '0;
  // a strobe only counts on a channel that is misaligned now
  assign set_mask   = misaligned & chan_check_in;

  always_comb
  begin
    flags_d = flags_q;
    for (int ch = 0; ch < NUM_CHANNELS; ch++)
    begin
      // set beats a clear landing in the same cycle
      if (set_mask[ch])
      begin
        flags_d[ch] = 1'b1;
      end
      else if (clear_mask[ch])
      begin
        flags_d[ch] = 1'b0;
      end
    end
  end

  always_comb
  begin
    unmask_d = unmask_q;
    if (wr_unmask)
    begin
      // strobes pick lanes, untouched lanes keep their bits
      unmask_d = (unmask_q & ~byte_mask) | (pwdata_in & byte_mask);
    end
  end

  // irq is registered from flags_d, so it changes in the same cycle as the flags;
  // it uses the old unmask, so an unmask write shows a cycle later
  assign irq_d = flags_d & unmask_q;

  // reads of an unmapped offset return zero
  always_comb
  begin
    rdata_d = '0;
    if (sel_flags)
    begin
      rdata_d = flags_q;
    end
    else if (sel_unmask)
    begin
      rdata_d = unmask_q;
    end
  end

  // a low clock enable freezes every register below
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      flags_q <= RST_ALIGN_FLAGS;
    end
    else if (ce_in)
    begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      unmask_q <= RST_ALIGN_UNMASK;
    end
    else if (ce_in)
    begin
      unmask_q <= unmask_d;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      align_error_irq_out <= '0;
    end
    else if (ce_in)
    begin
      align_error_irq_out <= irq_d;
    end
  end

  // exactly one wait state: answer on the second access cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_out <= answer;
    end
  end

  // unmapped offsets answer with an error, writes are dropped
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pslverr_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pslverr_out <= answer && !mapped;
    end
  end

  // read data captured before any same-cycle clear lands
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      prdata_out <= '0;
    end
    else if (ce_in)
    begin
      prdata_out <= rd_answer ? rdata_d : '0;
    end
  end
endmodule

// ===== dae_assertions.sv
// checker for the alignment error status block, bound to its ports
// assumes clock enable held high and full-word apb strobes
`timescale 1ns/1ps
module dae_chk (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] chan_check_in,
  input wire logic [63:0] channel_item_width_in,
  input wire logic [63:0] src_addr_low_in,
  input wire logic [63:0] dst_addr_low_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] align_error_irq_out
);
  logic [31:0] um_q;
  logic [1:0]  w, s, d;
  logic        wr, mis;
  assign w = channel_item_width_in[1:0];
  assign s = src_addr_low_in[1:0];
  assign d = dst_addr_low_in[1:0];
  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  assign mis = (w == 2'h3 && (s | d) != 2'h0) || (w == 2'h2 && (s[0] | d[0]));
  // unmask mirror; ignores strobes, so partial writes would confuse it
  always_ff @(posedge sys_clk_in)
    if (srst_in) um_q <= '0;
    else if (wr && paddr_in == 12'h018) um_q <= pwdata_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_answer; !pready_out ##1 pready_out; endsequence
  a_one_wait: assert property (s_setup |=> s_answer) else $error("no single wait");
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready held");
  a_err_map: assert property (pready_out |-> pslverr_out == !(paddr_in inside {12'h018, 12'h01c}))
    else $error("slverr wrong");
  a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !pready_out && align_error_irq_out == '0)
    else $error("reset left output");
  a_set_irq: assert property (chan_check_in[0] && mis && um_q[0] |=> align_error_irq_out[0])
    else $error("misalign not flagged");
  a_irq_gated: assert property ((align_error_irq_out & ~um_q & ~$past(um_q)) == '0) else $error("masked irq");
  a_sticky_flag: assert property (align_error_irq_out[0] && um_q[0] && !wr |=> align_error_irq_out[0])
    else $error("lost");
  a_clear_drop: assert property (wr && paddr_in == 12'h01c && pwdata_in[0] && !chan_check_in[0] |=>
    !align_error_irq_out[0]) else $error("flag not cleared");
endmodule
bind dae_align_error_status dae_chk i_dae_chk (.*);

// ===== dae_align_error_status_bench.sv
// self-checking bench for the alignment error status block
// drives apb and channel inputs itself; clock enable held high
`timescale 1ns/1ps
module dae_align_error_status_bench;
  logic        sys_clk_in = 0, srst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out, err;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, chan_check_in = '0, prdata_out, align_error_irq_out, rd, exp;
  logic [63:0] channel_item_width_in = '0, src_addr_low_in = '0, dst_addr_low_in = '0;
  int          error_cnt = 0, checked = 0;
  dae_align_error_status i_dae_align_error_status (.ce_in(1'b1), .pstrb_in(4'hf), .*);
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  task automatic cmp(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1 && n++ < 20);
    rd = prdata_out;
    err = pslverr_out;
    cmp(pready_out, 32'h1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // channel n gets width/address codes from n+3, so all widths appear
  task automatic strobe(input logic fix);
    for (int n = 0; n < 32; n++)
    begin
      channel_item_width_in[2*n+:2] <= 2'(n + 3);
      src_addr_low_in[2*n+:2] <= fix ? 2'h0 : 2'((n + 3) >> 1);
      dst_addr_low_in[2*n+:2] <= fix ? 2'h0 : 2'((n + 3) >> 4);
    end
    chan_check_in <= '1;
    @(posedge sys_clk_in);
    chan_check_in <= '0;
    if (!fix)
    for (int n = 0; n < 32; n++)
      exp[n] = ((n + 3) % 4 == 3 && ((((n + 3) >> 1) % 4) | (((n + 3) >> 4) % 4)) != 0) ||
               ((n + 3) % 4 == 2 && (((((n + 3) >> 1) | ((n + 3) >> 4)) & 1) == 1));
  endtask
  task automatic t_detect;
    apb(0, 12'h01c, 0);
    cmp(rd, 0);
    strobe(0);
    apb(0, 12'h01c, 0);
    cmp(rd, exp);
    cmp(align_error_irq_out, 0);
    $display("detect done");
  endtask
  task automatic t_clear;
    apb(1, 12'h018, 32'hffff_ffff);
    strobe(0);
    cmp(align_error_irq_out, exp);
    strobe(1);
    apb(1, 12'h01c, 0);
    apb(0, 12'h01c, 0);
    cmp(rd, exp);
    apb(1, 12'h01c, 32'h0000_ffff);
    apb(0, 12'h01c, 0);
    cmp(rd, exp & 32'hffff_0000);
    cmp(align_error_irq_out, exp & 32'hffff_0000);
    apb(0, 12'h020, 0);
    cmp(rd, 0);
    cmp(err, 1);
    apb(1, 12'h018, 0);
    @(posedge sys_clk_in);
    cmp(align_error_irq_out, 0);
    $display("clear done");
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_detect();
    t_clear();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk_in);
    error_cnt++;
    $display("MISMATCH %0t watchdog", $time);
    give_verdict();
  end
endmodule
